// ==== inc/cantx_pkg.sv ====
// Constants, register map and mailbox bit mapping for the CAN transmit mailbox control.
// Assumes a 25 MHz system clock and a protocol engine that reports per-mailbox events.
package cantx_pkg;

    localparam int unsigned AW = 5;

    localparam logic [AW-1:0] OFS_PEND   = 5'h00;
    localparam logic [AW-1:0] OFS_CANCEL = 5'h04;
    localparam logic [AW-1:0] OFS_DONE   = 5'h08;
    localparam logic [AW-1:0] OFS_ABORT  = 5'h0c;
    localparam logic [AW-1:0] OFS_IRQST  = 5'h10;
    localparam logic [AW-1:0] OFS_IRQMSK = 5'h14;

    localparam int unsigned RSV_POS    = 8;
    localparam logic [15:0] MB_MASK    = 16'hfeff;
    localparam logic [15:0] PEND_RSV   = 16'h0100;
    localparam logic [15:0] VEC_RST    = 16'h0000;

    localparam int unsigned IRQ_TX_POS = 0;
    localparam int unsigned IRQ_AB_POS = 1;
    localparam logic [1:0]  IRQ_RST    = 2'h0;

    typedef enum logic [2:0] {
        CANTX_R_PEND,
        CANTX_R_CANCEL,
        CANTX_R_DONE,
        CANTX_R_ABORT,
        CANTX_R_IRQST,
        CANTX_R_IRQMSK,
        CANTX_R_NONE
    } cantx_reg_t;

    // Register layout bit position for mailbox 1..15
    function automatic int unsigned cantx_mb_pos(input int unsigned mb);
        return (mb <= 7) ? mb + 8 : mb - 8;
    endfunction

    // Mailbox-indexed vector (bit 0 unused) into register layout
    function automatic logic [15:0] cantx_mb_to_reg(input logic [15:1] mb_vec);
        logic [15:0] r;
        r = 16'h0000;
        for (int unsigned n = 1; n <= 15; n++)
        begin
            r[cantx_mb_pos(n)] = mb_vec[n];
        end
        return r;
    endfunction

    // Register layout into mailbox-indexed vector
    function automatic logic [15:1] cantx_reg_to_mb(input logic [15:0] r);
        logic [15:1] m;
        m = 15'h0000;
        for (int unsigned n = 1; n <= 15; n++)
        begin
            m[n] = r[cantx_mb_pos(n)];
        end
        return m;
    endfunction

    function automatic cantx_reg_t cantx_decode(input logic [AW-1:0] a);
        unique case (a)
            OFS_PEND:   return CANTX_R_PEND;
            OFS_CANCEL: return CANTX_R_CANCEL;
            OFS_DONE:   return CANTX_R_DONE;
            OFS_ABORT:  return CANTX_R_ABORT;
            OFS_IRQST:  return CANTX_R_IRQST;
            OFS_IRQMSK: return CANTX_R_IRQMSK;
            default:    return CANTX_R_NONE;
        endcase
    endfunction

endpackage

// ==== inc/cantx_reg_if.sv ====
// Register access strobes between the APB slave and the mailbox core.
// Assumes both ends run on the same clock.
interface cantx_reg_if;
    import cantx_pkg::*;
    logic        wr_en;
    cantx_reg_t  sel;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport slv  (output wr_en, output sel, output wdata, input rdata);
    modport core (input wr_en, input sel, input wdata, output rdata);
endinterface

// ==== design/cantx_apb_slv.sv ====
// APB slave front end: one wait state, registered answer, error on unmapped address.
// Assumes a well-behaved APB master holding the request until pready.
module cantx_apb_slv
    import cantx_pkg::*;
(
    input  wire logic          clk,     // System clock
    input  wire logic          rst,     // Asynchronous reset
    input  wire logic          psel,    // APB select
    input  wire logic          penable, // APB enable
    input  wire logic          pwrite,  // APB direction
    input  wire logic [31:0]   paddr,   // APB byte address
    input  wire logic [31:0]   pwdata,  // APB write data
    output logic               pready,  // APB ready
    output logic [31:0]        prdata,  // APB read data
    output logic               pslverr, // APB error
    cantx_reg_if.slv           rif      // Core register strobes
);
    logic        pready_q, pready_d;
    logic        perr_q, perr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        mapped;
    cantx_reg_t  sel;

    always_comb
    begin
        mapped   = (paddr[31:AW] == '0);
        sel      = mapped ? cantx_decode(paddr[AW-1:0]) : CANTX_R_NONE;
        pready_d = psel & penable & ~pready_q;
        perr_d   = pready_d & (sel == CANTX_R_NONE);
        prdata_d = (pready_d & ~pwrite) ? {16'h0000, rif.rdata} : 32'h0000_0000;
        // Write lands on the edge where the master samples pready high
        rif.wr_en = psel & penable & pready_q & pwrite & ~perr_q;
        rif.sel   = sel;
        rif.wdata = pwdata[15:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            perr_q   <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= pready_d;
            perr_q   <= perr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready  = pready_q;
    assign pslverr = perr_q;
    assign prdata  = prdata_q;
endmodule // cantx_apb_slv

// ==== design/cantx_mbox_ctrl.sv ====
// Transmit mailbox control: pending, cancel, done and abort-done vectors, interrupt.
// Assumes the protocol engine pulses tx_ok/abort_ok for one cycle per completed mailbox.
//
// Implementation choices: the APB register port and the address map.
module cantx_mbox_ctrl
    import cantx_pkg::*;
(
    input  wire logic          clk,          // System clock, 25 MHz
    input  wire logic          rst,          // Asynchronous reset, active high
    input  wire logic          psel,         // APB select
    input  wire logic          penable,      // APB enable
    input  wire logic          pwrite,       // APB direction
    input  wire logic [31:0]   paddr,        // APB byte address
    input  wire logic [31:0]   pwdata,       // APB write data
    output logic               pready,       // APB ready
    output logic [31:0]        prdata,       // APB read data
    output logic               pslverr,      // APB error
    input  wire logic [15:1]   tx_ok_mb,     // Engine: mailbox sent error-free, pulse
    input  wire logic [15:1]   abort_ok_mb,  // Engine: mailbox cancel completed, pulse
    output logic [15:1]        tx_wait_mb,   // Mailboxes waiting for arbitration
    output logic [15:1]        cancel_mb,    // Mailboxes with cancel requested
    output logic               irq           // Level interrupt
);
    cantx_reg_if rif ();

    cantx_apb_slv u_apb (
        .clk     (clk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .rif     (rif)
    );

    logic [15:0] pend_q, pend_d;
    logic [15:0] cancel_q, cancel_d;
    logic [15:0] done_q, done_d;
    logic [15:0] abort_q, abort_d;
    logic [1:0]  irqst_q, irqst_d;
    logic [1:0]  irqmsk_q, irqmsk_d;
    logic        irq_q, irq_d;

    logic [15:0] ev_tx, ev_ab;
    logic [15:0] wr_val;
    logic        wr_pend, wr_cancel, wr_done, wr_abort, wr_irqst, wr_irqmsk;

    // Events only count for mailboxes that are actually waiting
    always_comb
    begin
        ev_tx = cantx_mb_to_reg(tx_ok_mb) & MB_MASK & pend_q;
        ev_ab = cantx_mb_to_reg(abort_ok_mb) & MB_MASK & pend_q & cancel_q;
        ev_tx = ev_tx & ~ev_ab;
    end

    always_comb
    begin
        wr_val    = rif.wdata & MB_MASK;
        wr_pend   = rif.wr_en & (rif.sel == CANTX_R_PEND);
        wr_cancel = rif.wr_en & (rif.sel == CANTX_R_CANCEL);
        wr_done   = rif.wr_en & (rif.sel == CANTX_R_DONE);
        wr_abort  = rif.wr_en & (rif.sel == CANTX_R_ABORT);
        wr_irqst  = rif.wr_en & (rif.sel == CANTX_R_IRQST);
        wr_irqmsk = rif.wr_en & (rif.sel == CANTX_R_IRQMSK);
    end

    // Mailbox vectors; a hardware set always wins over a same-cycle clear
    always_comb
    begin
        // Writing 0 to a pending bit is ignored; only completion clears it
        pend_d = pend_q & ~(ev_tx | ev_ab);
        if (wr_pend)
        begin
            pend_d = pend_d | wr_val;
        end
        // Cancel bit drops the cycle after its pending bit is gone
        cancel_d = cancel_q & pend_q;
        if (wr_cancel)
        begin
            cancel_d = cancel_d | wr_val;
        end
        done_d = done_q;
        if (wr_done)
        begin
            done_d = done_d & ~wr_val;
        end
        done_d = done_d | ev_tx;
        abort_d = abort_q;
        if (wr_abort)
        begin
            abort_d = abort_d & ~wr_val;
        end
        abort_d = abort_d | ev_ab;
    end

    // Interrupt status and mask
    always_comb
    begin
        irqst_d = irqst_q;
        if (wr_irqst)
        begin
            irqst_d = irqst_d & ~rif.wdata[1:0];
        end
        irqst_d[IRQ_TX_POS] = irqst_d[IRQ_TX_POS] | (|ev_tx);
        irqst_d[IRQ_AB_POS] = irqst_d[IRQ_AB_POS] | (|ev_ab);
        irqmsk_d = wr_irqmsk ? rif.wdata[1:0] : irqmsk_q;
        irq_d    = |(irqst_q & irqmsk_q);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q   <= VEC_RST;
            cancel_q <= VEC_RST;
            done_q   <= VEC_RST;
            abort_q  <= VEC_RST;
            irqst_q  <= IRQ_RST;
            irqmsk_q <= IRQ_RST;
            irq_q    <= 1'b0;
        end
        else
        begin
            pend_q   <= pend_d;
            cancel_q <= cancel_d;
            done_q   <= done_d;
            abort_q  <= abort_d;
            irqst_q  <= irqst_d;
            irqmsk_q <= irqmsk_d;
            irq_q    <= irq_d;
        end
    end

    // Read mux; reserved bit 8 of the pending vector reads as 1
    always_comb
    begin
        rif.rdata = 16'h0000;
        unique case (rif.sel)
            CANTX_R_PEND:   rif.rdata = pend_q | PEND_RSV;
            CANTX_R_CANCEL: rif.rdata = cancel_q & MB_MASK;
            CANTX_R_DONE:   rif.rdata = done_q & MB_MASK;
            CANTX_R_ABORT:  rif.rdata = abort_q & MB_MASK;
            CANTX_R_IRQST:  rif.rdata = {14'h0000, irqst_q};
            CANTX_R_IRQMSK: rif.rdata = {14'h0000, irqmsk_q};
            CANTX_R_NONE:   rif.rdata = 16'h0000;
        endcase
    end

    // Permutation of flip-flop bits only, so outputs still come straight from registers
    assign tx_wait_mb = cantx_reg_to_mb(pend_q);
    assign cancel_mb  = cantx_reg_to_mb(cancel_q);
    assign irq        = irq_q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // A write of one in the same cycle keeps a pending bit, so those bits are masked out
    logic [15:0] tx_ev_q;
    logic [15:0] wr_set_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_ev_q  <= 16'h0000;
            wr_set_q <= 16'h0000;
        end
        else
        begin
            tx_ev_q  <= ev_tx;
            wr_set_q <= wr_pend ? wr_val : 16'h0000;
        end
    end

    // Pending bit gone one cycle after the abort event
    sequence s_cancel_done;
        ((pend_q & $past(ev_ab) & ~wr_set_q) == 16'h0000);
    endsequence

    sequence s_cancel_clear;
        ((cancel_q & $past(ev_ab, 2) & ~$past(wr_set_q)) == 16'h0000);
    endsequence

    pend_write_set_a : assert property (
        wr_pend |=> ((pend_q & $past(wr_val)) == $past(wr_val)))
        else $error("pending bit not set by write of one");

    pend_rsv_a : assert property (
        (rif.sel == CANTX_R_PEND) |-> rif.rdata[RSV_POS])
        else $error("pending bit 8 does not read as one");

    rsv_zero_a : assert property (
        !cancel_q[RSV_POS] && !done_q[RSV_POS] && !pend_q[RSV_POS])
        else $error("reserved bit 8 stored a value");

    tx_clear_set_a : assert property (
        (ev_tx != 16'h0000) |=> ((pend_q & tx_ev_q & ~wr_set_q) == 16'h0000)
            && ((done_q & tx_ev_q) == tx_ev_q))
        else $error("transmit done did not clear pending and set done together");

    cancel_flow_a : assert property (
        (ev_ab != 16'h0000) |=> s_cancel_done ##1 s_cancel_clear)
        else $error("cancel did not clear pending then cancel bit");

    abort_set_a : assert property (
        (ev_ab != 16'h0000) |=> ((abort_q & $past(ev_ab)) == $past(ev_ab)))
        else $error("abort-done flag not set on cancel completion");

    stray_cancel_a : assert property (
        ((cancel_q & ~pend_q) != 16'h0000) && !wr_cancel && !wr_abort && (ev_ab == 16'h0000)
            |=> (cancel_q & $past(cancel_q & ~pend_q)) == 16'h0000
            && $stable(abort_q))
        else $error("stray cancel not dropped quietly");

    done_w1c_a : assert property (
        wr_done && (ev_tx == 16'h0000)
            |=> done_q == ($past(done_q) & ~$past(wr_val)))
        else $error("done flags did not follow write-one-to-clear");

    pend_hold_a : assert property (
        (ev_tx == 16'h0000) && (ev_ab == 16'h0000)
            |=> (pend_q & $past(pend_q)) == $past(pend_q))
        else $error("pending bit cleared without completion");

    irq_level_a : assert property (
        ((irqst_q & irqmsk_q) != 2'h0) |=> irq)
        else $error("interrupt not raised for unmasked status");

    irq_low_a : assert property (
        ((irqst_q & irqmsk_q) == 2'h0) |=> !irq)
        else $error("interrupt raised with no unmasked status");

    irqst_tx_a : assert property (
        (ev_tx != 16'h0000) |=> irqst_q[IRQ_TX_POS])
        else $error("transmit status not set on transmit done");

    irqst_ab_a : assert property (
        (ev_ab != 16'h0000) |=> irqst_q[IRQ_AB_POS])
        else $error("abort status not set on cancel completion");

    msk_write_a : assert property (
        wr_irqmsk |=> (irqmsk_q == $past(rif.wdata[1:0])))
        else $error("interrupt mask did not take written value");

    // Bus side: one wait state, and every answer stands for a single cycle
    apb_wait_a : assert property (
        psel && penable && !pready |=> pready)
        else $error("ready not given after one wait state");

    ready_pulse_a : assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    err_ready_a : assert property (
        pslverr |-> pready)
        else $error("error raised without ready");

    idle_rdata_a : assert property (
        !pready |-> (prdata == 32'h0000_0000))
        else $error("read data not zero outside an answer");

    // Flag vectors
    cancel_set_a : assert property (
        wr_cancel |=> ((cancel_q & $past(wr_val)) == $past(wr_val)))
        else $error("cancel bit not set by write of one");

    // Cancel must outlive its pending bit, so the engine never sees a half-done abort
    cancel_hold_a : assert property (
        ((cancel_q & pend_q) != 16'h0000)
            |=> (cancel_q & $past(cancel_q & pend_q)) == $past(cancel_q & pend_q))
        else $error("cancel bit dropped while its mailbox still waits");

    rdata_rsv_a : assert property (
        ((rif.sel == CANTX_R_CANCEL) || (rif.sel == CANTX_R_DONE))
            |-> !rif.rdata[RSV_POS])
        else $error("reserved bit 8 of cancel or done reads as one");

    done_hold_a : assert property (
        !wr_done && (ev_tx == 16'h0000) |=> $stable(done_q))
        else $error("done flags changed without event or write");

    abort_hold_a : assert property (
        !wr_abort && (ev_ab == 16'h0000) |=> $stable(abort_q))
        else $error("abort-done flags changed without event or write");

    abort_w1c_a : assert property (
        wr_abort && (ev_ab == 16'h0000)
            |=> abort_q == ($past(abort_q) & ~$past(wr_val)))
        else $error("abort-done flags did not follow write-one-to-clear");

endmodule // cantx_mbox_ctrl

// ==== design/cantx_unused_guard.sv ====
// Holds no logic: every module of the block lives in a file of its own name.

// ==== dv/cantx_engine_model.sv ====
// Behavioural protocol engine standing in for the bus side of the mailboxes.
// Assumes the mailbox control takes completion pulses on the next rising edge.
module cantx_engine_model
(
    input  wire logic        clk,         // System clock
    input  wire logic        rst,         // Asynchronous reset
    input  wire logic [15:1] tx_wait_mb,  // Pending mailboxes
    input  wire logic [15:1] cancel_mb,   // Cancel requests
    input  wire logic [15:1] win_mb,      // Mailboxes that may win arbitration
    input  wire logic [3:0]  dly,         // One less than the cycles spent per frame or abort
    output logic      [15:1] tx_ok_mb,    // Transmit done pulse
    output logic      [15:1] abort_ok_mb  // Cancel done pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  cnt_q;
    logic [15:1] busy;
    // Only pending mailboxes that may win or have a cancel request keep the engine busy
    assign busy = (cancel_mb | win_mb) & tx_wait_mb;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q       <= 4'h0;
            tx_ok_mb    <= 15'h0;
            abort_ok_mb <= 15'h0;
        end
        else
        begin
            tx_ok_mb    <= 15'h0;
            abort_ok_mb <= 15'h0;
            // Hold off while a pulse is still unanswered, or it would repeat
            if (busy != 15'h0 && tx_ok_mb == 15'h0 && abort_ok_mb == 15'h0)
            begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == dly)
                begin
                    cnt_q       <= 4'h0;
                    abort_ok_mb <= cancel_mb & tx_wait_mb;
                    tx_ok_mb    <= win_mb & tx_wait_mb & ~cancel_mb;
                end
            end
            else
            begin
                cnt_q <= 4'h0;
            end
        end
    end
endmodule // cantx_engine_model

// ==== dv/can_tx_mailbox_control_tb.sv ====
// Self-checking bench for the transmit mailbox control over APB.
// Assumes the engine model on the far side and one 25 MHz clock.
module can_tx_mailbox_control_tb
    import cantx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [15:1] tx_ok_mb;
    logic [15:1] abort_ok_mb;
    logic [15:1] tx_wait_mb;
    logic [15:1] cancel_mb;
    logic        irq;
    logic [15:1] win_mb;
    logic [3:0]  dly;
    logic [31:0] rd;
    logic        er;
    int          n_fail;
    int          checks_done;

    cantx_mbox_ctrl cantx_mbox_ctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tx_ok_mb(tx_ok_mb), .abort_ok_mb(abort_ok_mb),
        .tx_wait_mb(tx_wait_mb), .cancel_mb(cancel_mb), .irq(irq));
    cantx_engine_model cantx_engine_model_i (.clk(clk), .rst(rst), .tx_wait_mb(tx_wait_mb),
        .cancel_mb(cancel_mb), .win_mb(win_mb), .dly(dly), .tx_ok_mb(tx_ok_mb),
        .abort_ok_mb(abort_ok_mb));

    task automatic conclude;
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register bit of mailbox n, worked out independently of the design
    function automatic logic [15:0] mbit(input int n);
        return 16'h1 << ((n <= 7) ? n + 8 : n - 8);
    endfunction

    task automatic apb(input logic w, input logic [4:0] a, input logic [15:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {27'h0, a};
        pwdata  <= {16'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (k >= 50)
        begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0);
        chk(rd, {16'h0, e});
    endtask

    task automatic wait_low(input logic [15:1] m);
        int k;
        k = 0;
        while ((tx_wait_mb & m) != 15'h0 && k < 60)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 60)
        begin
            n_fail++;
            conclude();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset;
        rdc(OFS_PEND, PEND_RSV);
        rdc(OFS_CANCEL, 16'h0000);
        rdc(OFS_DONE, 16'h0000);
        apb(1'b0, 5'h18, 16'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task automatic t_map;
        logic [15:1] m;
        for (int n = 1; n <= 15; n++)
        begin
            m = 15'h1 << (n - 1);
            dly <= (n > 7) ? 4'h6 : 4'h0;
            apb(1'b1, OFS_PEND, mbit(n) | PEND_RSV);
            @(posedge clk);
            chk({17'h0, tx_wait_mb}, {17'h0, m});
            rdc(OFS_PEND, mbit(n) | PEND_RSV);
            win_mb <= m;
            wait_low(m);
            win_mb <= 15'h0;
            rdc(OFS_DONE, mbit(n));
            apb(1'b1, OFS_DONE, 16'h0000);
            rdc(OFS_DONE, mbit(n));
            apb(1'b1, OFS_DONE, mbit(n));
            rdc(OFS_DONE, 16'h0000);
        end
    endtask

    task automatic t_cancel;
        apb(1'b1, OFS_IRQST, 16'h0003);
        apb(1'b1, OFS_IRQMSK, 16'h0003);
        rdc(OFS_IRQMSK, 16'h0003);
        apb(1'b1, OFS_PEND, mbit(3) | mbit(12) | PEND_RSV);
        apb(1'b1, OFS_CANCEL, mbit(3));
        wait_low(15'h1 << 2);
        chk({17'h0, cancel_mb}, 32'h0);
        chk({17'h0, tx_wait_mb}, {17'h0, 15'h1 << 11});
        rdc(OFS_ABORT, mbit(3));
        rdc(OFS_DONE, 16'h0000);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQMSK, 16'h0000);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_IRQST, 16'h0002);
        apb(1'b1, OFS_IRQST, 16'h0003);
        rdc(OFS_IRQST, 16'h0000);
        apb(1'b1, OFS_ABORT, mbit(3));
        // Mailbox 5 is not pending, so nothing reaches the bus
        apb(1'b1, OFS_CANCEL, mbit(5));
        repeat (3) @(posedge clk);
        chk({17'h0, cancel_mb}, 32'h0);
        rdc(OFS_ABORT, 16'h0000);
        apb(1'b1, OFS_CANCEL, 16'h0100);
        rdc(OFS_CANCEL, 16'h0000);
        apb(1'b1, OFS_DONE, 16'h0100);
        rdc(OFS_DONE, 16'h0000);
        win_mb <= 15'h1 << 11;
        wait_low(15'h1 << 11);
        rdc(OFS_DONE, mbit(12));
        rdc(OFS_IRQST, 16'h0001);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        n_fail = 0;
        checks_done = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        win_mb = 15'h0;
        dly = 4'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_map();
        t_cancel();
        conclude();
    end
endmodule // can_tx_mailbox_control_tb
